// ---- core/pwr_pkg.sv ----
/*
  Constants shared by the PWM reload, sync and interrupt control block.
  Assumes an APB master with 32-bit data and byte addresses.
*/
// What this block does
// - Centre mode, dir 0: sync on upcount
// - Centre mode, dir 1: sync on downcount
// - Direction select ignored outside centre mode
// - Direction select double-buffered via load arm
// - Count writes land in holding buffers
// - Load arm required while running; all copy together
// - Immediate: load at next period event
// - Triggered: arm waits for peer load
// - Triggered: load at period after trigger
// - Buffer load clears load arm
// - Arm during period match waits one period
// - Runs in sleep on internal oscillators
// - Four flags set on match rising edge
// - Control bit 7 enables the channel
// - Control bit 6 drives output pin
// - Control bit 5 mirrors waveform level
// - Control bit 4 inverts active level
// - Control bits 3-2 select waveform mode
// - Enable bits 3-0 gate match interrupts
// - Unimplemented bits read as zero
// - Disabled channel holds flags cleared
// - Divide field selects power-of-two divisor
// - Source field: system, fast, slow
// - Standard mode period match clears timer
package pwr_pkg;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_IRQ_EN = 8'h04;
  localparam logic [7:0] OFF_FLAGS  = 8'h08;
  localparam logic [7:0] OFF_CLKCFG = 8'h0c;
  localparam logic [7:0] OFF_SYNCFG = 8'h10;
  localparam logic [7:0] OFF_RLDCFG = 8'h14;
  localparam logic [7:0] OFF_START  = 8'h18;
  localparam logic [7:0] OFF_DUTY   = 8'h1c;
  localparam logic [7:0] OFF_PERIOD = 8'h20;
  localparam logic [7:0] OFF_SYNC   = 8'h24;
  localparam logic [7:0] OFF_TIMER  = 8'h28;
  localparam int BIT_ON      = 7;
  localparam int BIT_PIN     = 6;
  localparam int BIT_LEVEL   = 5;
  localparam int BIT_INV     = 4;
  localparam int BIT_MODE    = 2;
  localparam int BIT_DIV     = 4;
  localparam int BIT_SRC     = 0;
  localparam int BIT_DIR     = 0;
  localparam int BIT_ARM     = 7;
  localparam int BIT_TRG     = 6;
  localparam int BIT_TSRC    = 0;
  localparam int FLG_SYNC    = 3;
  localparam int FLG_START   = 2;
  localparam int FLG_DUTY    = 1;
  localparam int FLG_PERIOD  = 0;
  localparam logic [1:0] MODE_STD    = 2'h0;
  localparam logic [1:0] MODE_SET    = 2'h1;
  localparam logic [1:0] MODE_TOGGLE = 2'h2;
  localparam logic [1:0] MODE_CENTRE = 2'h3;
  localparam logic [1:0] SRC_SYS     = 2'h0;
  localparam logic [1:0] SRC_FAST    = 2'h1;
  localparam logic [1:0] SRC_SLOW    = 2'h2;
  localparam logic [15:0] RST_COUNT  = 16'h0000;
  localparam logic [7:0]  RST_REG8   = 8'h00;
endpackage

// ---- core/pwr_clk_div.sv ----
/*
  Clock source select and power-of-two prescaler producing a tick enable.
  Assumes the oscillator inputs are asynchronous square waves slower than i_mclk / 2.
*/
`timescale 1ns/100ps
module pwr_clk_div (
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_fast_osc,
  input  wire logic       i_slow_osc,
  input  wire logic       i_sleep,
  input  wire logic [1:0] i_src,
  input  wire logic [2:0] i_div,
  output logic            o_tick
);
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [6:0] cnt;
    logic       tick;
  } pwr_div_state_type;

  pwr_div_state_type st_r;
  pwr_div_state_type st_nxt;

  function automatic logic [6:0] div_mask(input logic [2:0] d);
    div_mask = 7'((8'h01 << d) - 8'h01);
  endfunction

  logic       src_tick;
  logic [6:0] mask;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {i_slow_osc, i_fast_osc};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = st_r.sync2;
    mask = div_mask(i_div);
    case (i_src)
      pwr_pkg::SRC_SYS:  src_tick = !i_sleep;
      pwr_pkg::SRC_FAST: src_tick = st_r.sync2[0] & !st_r.prev[0];
      pwr_pkg::SRC_SLOW: src_tick = st_r.sync2[1] & !st_r.prev[1];
      default:           src_tick = 1'b0;
    endcase
    st_nxt.tick = src_tick && ((st_r.cnt & mask) == mask);
    if (src_tick) begin
      st_nxt.cnt = st_r.cnt + 7'h01;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_tick = st_r.tick;
endmodule // pwr_clk_div

// ---- core/pwr_ctrl.sv ----
/*
  PWM channel control: APB registers, double-buffered reload with immediate
  or triggered arming, centre-mode sync match direction and four match flags.
  Assumes the timer, direction and match inputs come from the channel counter
  on i_mclk, and peer load pulses from sibling channels on the same clock.
*/
// Local design decisions: the address map and register access over APB.
`timescale 1ns/100ps
module pwr_ctrl (
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] i_timer,
  input  wire logic        i_count_down,
  input  wire logic        i_start_match,
  input  wire logic        i_duty_match,
  input  wire logic        i_wave_level,
  input  wire logic [3:0]  i_peer_load,
  input  wire logic        i_fast_osc,
  input  wire logic        i_slow_osc,
  input  wire logic        i_sleep,
  output logic             o_module_on,
  output logic [1:0]       o_mode,
  output logic [15:0]      o_start_count,
  output logic [15:0]      o_duty_value,
  output logic [15:0]      o_period_limit,
  output logic             o_sync_match,
  output logic             o_timer_clear,
  output logic             o_load_event,
  output logic             o_pwm_tick,
  output logic             o_pin_out,
  output logic             o_pin_oe,
  output logic             o_irq
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic        on;
    logic        pin;
    logic        level;
    logic        inv;
    logic [1:0]  mode;
    logic [3:0]  irq_en;
    logic [3:0]  flags;
    logic [2:0]  div;
    logic [1:0]  src;
    logic        hold_dir;
    logic        op_dir;
    logic        load_arm;
    logic        trg_sel;
    logic [1:0]  trg_src;
    logic        trg_seen;
    logic        ready;
    logic [15:0] hold_start;
    logic [15:0] hold_duty;
    logic [15:0] hold_period;
    logic [15:0] hold_sync;
    logic [15:0] op_start;
    logic [15:0] op_duty;
    logic [15:0] op_period;
    logic [15:0] op_sync;
    logic [3:0]  prev;
    logic        sync_match;
    logic        timer_clear;
    logic        load_pulse;
    logic        pin_out;
    logic        irq;
    logic [31:0] rdata;
    logic        rdy;
    logic        err;
  } pwr_state_type;

  pwr_state_type st_r;
  pwr_state_type st_nxt;

  function automatic logic [15:0] upd16(input logic [15:0] cur,
                                        input logic        we,
                                        input logic [31:0] d);
    upd16 = we ? d[15:0] : cur;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= pwr_pkg::OFF_TIMER);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic       wr;
  logic       setup;
  logic       sync_hit;
  logic       dir_ok;
  logic       per_hit;
  logic       per_rise;
  logic [3:0] cur;
  logic [3:0] edges;
  logic       qual;
  logic       load;
  logic       active;

  pwr_clk_div u_div (
    .i_mclk     (i_mclk),
    .i_reset_n  (i_reset_n),
    .i_fast_osc (i_fast_osc),
    .i_slow_osc (i_slow_osc),
    .i_sleep    (i_sleep),
    .i_src      (st_r.src),
    .i_div      (st_r.div),
    .o_tick     (o_pwm_tick)
  );

  always_comb begin
    st_nxt = st_r;
    setup  = psel && !penable;
    wr     = psel && penable && pwrite && mapped(paddr);

    // Sync match direction only matters in centre mode
    if (st_r.mode == pwr_pkg::MODE_CENTRE) begin
      dir_ok = st_r.op_dir ? i_count_down : !i_count_down;
    end else begin
      dir_ok = 1'b1;
    end
    sync_hit = st_r.on && (i_timer == st_r.op_sync) && dir_ok;
    per_hit  = st_r.on && (i_timer == st_r.op_period);
    cur      = {sync_hit, i_start_match, i_duty_match, per_hit};
    edges    = cur & ~st_r.prev;
    per_rise = edges[pwr_pkg::FLG_PERIOD];
    st_nxt.prev = cur;
    st_nxt.sync_match  = sync_hit;
    st_nxt.timer_clear = per_rise && (st_r.mode == pwr_pkg::MODE_STD);
    st_nxt.level = i_wave_level;

    // Register writes
    if (wr) begin
      case (paddr)
        pwr_pkg::OFF_CTRL: begin
          st_nxt.on   = pwdata[pwr_pkg::BIT_ON];
          st_nxt.pin  = pwdata[pwr_pkg::BIT_PIN];
          st_nxt.inv  = pwdata[pwr_pkg::BIT_INV];
          st_nxt.mode = pwdata[pwr_pkg::BIT_MODE +: 2];
        end
        pwr_pkg::OFF_IRQ_EN: st_nxt.irq_en = pwdata[3:0];
        pwr_pkg::OFF_FLAGS:  st_nxt.flags  = pwdata[3:0];
        pwr_pkg::OFF_CLKCFG: begin
          st_nxt.div = pwdata[pwr_pkg::BIT_DIV +: 3];
          st_nxt.src = pwdata[pwr_pkg::BIT_SRC +: 2];
        end
        pwr_pkg::OFF_SYNCFG: st_nxt.hold_dir = pwdata[pwr_pkg::BIT_DIR];
        pwr_pkg::OFF_RLDCFG: begin
          st_nxt.load_arm = pwdata[pwr_pkg::BIT_ARM];
          st_nxt.trg_sel  = pwdata[pwr_pkg::BIT_TRG];
          st_nxt.trg_src  = pwdata[pwr_pkg::BIT_TSRC +: 2];
        end
        default: ;
      endcase
    end
    st_nxt.hold_start  = upd16(st_r.hold_start,  wr && paddr == pwr_pkg::OFF_START,  pwdata);
    st_nxt.hold_duty   = upd16(st_r.hold_duty,   wr && paddr == pwr_pkg::OFF_DUTY,   pwdata);
    st_nxt.hold_period = upd16(st_r.hold_period, wr && paddr == pwr_pkg::OFF_PERIOD, pwdata);
    st_nxt.hold_sync   = upd16(st_r.hold_sync,   wr && paddr == pwr_pkg::OFF_SYNC,   pwdata);

    // Match events set flags; a set beats a same-cycle software clear
    st_nxt.flags = st_nxt.flags | edges;
    if (!st_nxt.on) begin
      st_nxt.flags = 4'h0;
    end

    // Arming: the trigger only counts once the arm is set
    if (st_r.trg_sel && st_r.load_arm && i_peer_load[st_r.trg_src]) begin
      st_nxt.trg_seen = 1'b1;
    end
    qual = st_r.load_arm && (!st_r.trg_sel || st_r.trg_seen);
    // An arm that lands on a period match waits for the next event
    if (qual && !per_hit) begin
      st_nxt.ready = 1'b1;
    end
    load = per_rise && st_r.ready;
    st_nxt.load_pulse = load;
    if (load) begin
      st_nxt.op_start  = st_r.hold_start;
      st_nxt.op_duty   = st_r.hold_duty;
      st_nxt.op_period = st_r.hold_period;
      st_nxt.op_sync   = st_r.hold_sync;
      st_nxt.op_dir    = st_r.hold_dir;
      st_nxt.load_arm  = 1'b0;
      st_nxt.trg_seen  = 1'b0;
      st_nxt.ready     = 1'b0;
    end
    if (!st_r.load_arm && !load) begin
      st_nxt.trg_seen = 1'b0;
      st_nxt.ready    = 1'b0;
    end

    // A stopped channel follows its buffers directly
    active = st_r.on;
    if (!active) begin
      st_nxt.op_start  = st_r.hold_start;
      st_nxt.op_duty   = st_r.hold_duty;
      st_nxt.op_period = st_r.hold_period;
      st_nxt.op_sync   = st_r.hold_sync;
      st_nxt.op_dir    = st_r.hold_dir;
    end

    // Polarity applies even when disabled
    st_nxt.pin_out = st_nxt.pin && (st_nxt.level ^ st_nxt.inv);
    st_nxt.irq     = |(st_nxt.flags & st_nxt.irq_en);

    // APB read data captured in the setup cycle, answered next cycle
    st_nxt.rdy   = setup;
    st_nxt.err   = setup && !mapped(paddr);
    st_nxt.rdata = 32'h0000_0000;
    if (setup && !pwrite) begin
      case (paddr)
        pwr_pkg::OFF_CTRL:   st_nxt.rdata[7:0] = {st_r.on, st_r.pin, st_r.level,
                                                  st_r.inv, st_r.mode, 2'h0};
        pwr_pkg::OFF_IRQ_EN: st_nxt.rdata[3:0] = st_r.irq_en;
        pwr_pkg::OFF_FLAGS:  st_nxt.rdata[3:0] = st_r.flags;
        pwr_pkg::OFF_CLKCFG: st_nxt.rdata[7:0] = {1'b0, st_r.div, 2'h0, st_r.src};
        pwr_pkg::OFF_SYNCFG: st_nxt.rdata[0]   = st_r.hold_dir;
        pwr_pkg::OFF_RLDCFG: st_nxt.rdata[7:0] = {st_r.load_arm, st_r.trg_sel,
                                                  4'h0, st_r.trg_src};
        pwr_pkg::OFF_START:  st_nxt.rdata[15:0] = st_r.hold_start;
        pwr_pkg::OFF_DUTY:   st_nxt.rdata[15:0] = st_r.hold_duty;
        pwr_pkg::OFF_PERIOD: st_nxt.rdata[15:0] = st_r.hold_period;
        pwr_pkg::OFF_SYNC:   st_nxt.rdata[15:0] = st_r.hold_sync;
        pwr_pkg::OFF_TIMER:  st_nxt.rdata[15:0] = i_timer;
        default:             st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign prdata         = st_r.rdata;
  assign pready         = st_r.rdy;
  assign pslverr        = st_r.err;
  assign o_module_on    = st_r.on;
  assign o_mode         = st_r.mode;
  assign o_start_count  = st_r.op_start;
  assign o_duty_value   = st_r.op_duty;
  assign o_period_limit = st_r.op_period;
  assign o_sync_match   = st_r.sync_match;
  assign o_timer_clear  = st_r.timer_clear;
  assign o_load_event   = st_r.load_pulse;
  assign o_pin_out      = st_r.pin_out;
  assign o_pin_oe       = st_r.pin;
  assign o_irq          = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  sequence s_centre_up;
    st_r.mode == pwr_pkg::MODE_CENTRE && !st_r.op_dir && st_r.on;
  endsequence

  sequence s_centre_down;
    st_r.mode == pwr_pkg::MODE_CENTRE && st_r.op_dir && st_r.on;
  endsequence

  sequence s_armed_load;
    st_r.ready && per_rise && st_r.on;
  endsequence

  AST_SYNC_UP: assert property (s_centre_up ##0 (i_timer == st_r.op_sync)
    |=> o_sync_match == !$past(i_count_down))
    else $error("sync match direction wrong with dir select 0");

  AST_SYNC_DOWN: assert property (s_centre_down ##0 (i_timer == st_r.op_sync)
    |=> o_sync_match == $past(i_count_down))
    else $error("sync match direction wrong with dir select 1");

  AST_SYNC_NONCTR: assert property (st_r.on && st_r.mode != pwr_pkg::MODE_CENTRE
    && i_timer == st_r.op_sync |=> o_sync_match)
    else $error("sync match lost outside centre mode");

  AST_HOLD: assert property (st_r.on && $stable(st_r.on) && !$past(load)
    |-> $stable(st_r.op_period) && $stable(st_r.op_dir))
    else $error("operating value changed without a load");

  AST_LOAD: assert property (s_armed_load |=> o_load_event && !st_r.load_arm
    && o_period_limit == $past(st_r.hold_period) ##1 !o_load_event)
    else $error("buffer load incomplete");

  AST_COLLIDE: assert property (st_r.on && !st_r.ready && per_hit
    |=> !o_load_event && !st_r.ready)
    else $error("arm became ready on a period match");

  AST_TRIG: assert property (st_r.trg_sel && !st_r.trg_seen
    && !(st_r.load_arm && i_peer_load[st_r.trg_src]) |=> !st_r.ready)
    else $error("triggered arm without trigger");

  AST_FLAG: assert property (st_r.on && edges != 4'h0 && st_nxt.on
    |=> (st_r.flags & $past(edges)) == $past(edges))
    else $error("match edge did not set its flag");

  AST_FLAGS_OFF: assert property (!st_r.on |-> st_r.flags == 4'h0)
    else $error("flags set while disabled");

  AST_IRQ: assert property (##1 o_irq == |(st_r.flags & st_r.irq_en))
    else $error("interrupt output disagrees with flags");

  AST_APB: assert property (psel && !penable |=> pready ##1 !pready [*1])
    else $error("apb answer timing wrong");

  // Period handling, standard mode timer clear and grouped load
  sequence s_std_period;
    st_r.on && per_rise && st_r.mode == pwr_pkg::MODE_STD;
  endsequence

  AST_TIMER_CLR: assert property (s_std_period |=> o_timer_clear)
    else $error("standard mode period match did not clear the timer");

  AST_NO_CLR: assert property (st_r.mode != pwr_pkg::MODE_STD |=> !o_timer_clear)
    else $error("timer clear outside standard mode");

  AST_LOAD_ALL: assert property (s_armed_load |=> o_start_count == $past(st_r.hold_start)
    && o_duty_value == $past(st_r.hold_duty) && st_r.op_dir == $past(st_r.hold_dir))
    else $error("buffer pairs did not load together");

  // Control and enable read answers carry zeros in unimplemented bits; masked sources raise no interrupt
  AST_RD_CTRL: assert property (pready && paddr == pwr_pkg::OFF_CTRL
    |-> prdata[1:0] == 2'h0 && prdata[31:8] == 24'h0)
    else $error("unimplemented control bits read nonzero");

  AST_RD_IRQEN: assert property (pready && paddr == pwr_pkg::OFF_IRQ_EN
    |-> prdata[31:4] == 28'h0)
    else $error("unimplemented enable bits read nonzero");

  AST_IRQ_MASK: assert property (st_r.irq_en == 4'h0 |-> !o_irq)
    else $error("interrupt raised with every source masked");
endmodule // pwr_ctrl

// ---- bench/tb_top.sv ----
/*
  Self-checking bench for the PWM reload, sync and interrupt control block.
  Assumes pwr_ctrl answers APB with one access cycle and the bench plays the counter.
*/
`timescale 1ns/100ps
module tb_top;
  logic        i_mclk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic [15:0] i_timer = 16'h0;
  logic        i_count_down = 1'b0, i_start_match = 1'b0, i_duty_match = 1'b0;
  logic        i_wave_level = 1'b0, i_fast_osc = 1'b0, i_sleep = 1'b0;
  logic [3:0]  i_peer_load = 4'h0;
  logic        o_module_on, o_sync_match, o_timer_clear, o_load_event;
  logic        o_pwm_tick, o_pin_out, o_pin_oe, o_irq;
  logic [1:0]  o_mode;
  logic [15:0] o_start_count, o_duty_value, o_period_limit;
  int          n_fail = 0;
  int          n_tests = 0;
  logic        ld, clr;
  logic [31:0] rv;
  logic        re;

  always #50 i_mclk = ~i_mclk;
  // Internal fast oscillator stand-in, slower than half the bus clock
  always #400 i_fast_osc = ~i_fast_osc;

  pwr_ctrl u_pwr_ctrl (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_timer(i_timer), .i_count_down(i_count_down),
    .i_start_match(i_start_match), .i_duty_match(i_duty_match),
    .i_wave_level(i_wave_level), .i_peer_load(i_peer_load), .i_fast_osc(i_fast_osc),
    .i_slow_osc(1'b0), .i_sleep(i_sleep), .o_module_on(o_module_on), .o_mode(o_mode),
    .o_start_count(o_start_count), .o_duty_value(o_duty_value),
    .o_period_limit(o_period_limit), .o_sync_match(o_sync_match),
    .o_timer_clear(o_timer_clear), .o_load_event(o_load_event), .o_pwm_tick(o_pwm_tick),
    .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe), .o_irq(o_irq));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge i_mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    do begin
      @(posedge i_mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (k >= 20) begin
      n_fail++;
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rv);
  endtask

  task automatic waitn(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // One-cycle visit of the timer to a value, then watch for load and clear pulses
  task automatic per_pulse(input logic [15:0] v);
    ld = 1'b0;
    clr = 1'b0;
    for (int i = 0; i < 7; i++) begin
      @(posedge i_mclk);
      if (i == 0) i_timer <= v;
      if (i == 1) i_timer <= 16'h0;
      ld = ld | (o_load_event === 1'b1);
      clr = clr | (o_timer_clear === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rd("ctrl rst", pwr_pkg::OFF_CTRL, 32'h0);
    rd("irqen rst", pwr_pkg::OFF_IRQ_EN, 32'h0);
    rd("flags rst", pwr_pkg::OFF_FLAGS, 32'h0);
    wr(pwr_pkg::OFF_CTRL, 32'hff);
    rd("ctrl rw", pwr_pkg::OFF_CTRL, 32'hdc);
    chk("on", 32'h1, o_module_on);
    chk("mode", 32'h3, o_mode);
    wr(pwr_pkg::OFF_IRQ_EN, 32'hff);
    rd("irqen rw", pwr_pkg::OFF_IRQ_EN, 32'h0f);
    wr(pwr_pkg::OFF_IRQ_EN, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped err", 32'h1, re);
    chk("unmapped data", 32'h0, rv);
    @(posedge i_mclk); i_wave_level <= 1'b1;
    rd("level mirror", pwr_pkg::OFF_CTRL, 32'hfc);
    waitn(3);
    chk("pin inv", 32'h0, o_pin_out);
    chk("pin oe", 32'h1, o_pin_oe);
    wr(pwr_pkg::OFF_CTRL, 32'hc0);
    waitn(3);
    chk("pin true", 32'h1, o_pin_out);
    wr(pwr_pkg::OFF_CTRL, 32'h80);
    waitn(3);
    chk("pin off", 32'h0, o_pin_oe);
  endtask

  task automatic t_reload;
    wr(pwr_pkg::OFF_CTRL, 32'h0);
    wr(pwr_pkg::OFF_PERIOD, 32'h8);
    wr(pwr_pkg::OFF_CTRL, 32'h80);
    wr(pwr_pkg::OFF_PERIOD, 32'h20);
    wr(pwr_pkg::OFF_DUTY, 32'h11);
    wr(pwr_pkg::OFF_START, 32'h3);
    waitn(2);
    chk("held period", 32'h8, o_period_limit);
    wr(pwr_pkg::OFF_RLDCFG, 32'h80);
    per_pulse(16'h8);
    chk("imm load", 32'h1, ld);
    chk("std clear", 32'h1, clr);
    chk("imm period", 32'h20, o_period_limit);
    chk("imm duty", 32'h11, o_duty_value);
    chk("imm start", 32'h3, o_start_count);
    rd("arm cleared", pwr_pkg::OFF_RLDCFG, 32'h0);
  endtask

  task automatic t_trig;
    wr(pwr_pkg::OFF_RLDCFG, 32'hc2);
    wr(pwr_pkg::OFF_PERIOD, 32'h30);
    per_pulse(16'h20);
    chk("no trig", 32'h0, ld);
    @(posedge i_mclk); i_peer_load <= 4'h2;
    @(posedge i_mclk); i_peer_load <= 4'h0;
    per_pulse(16'h20);
    chk("wrong src", 32'h0, ld);
    @(posedge i_mclk); i_peer_load <= 4'h4;
    @(posedge i_mclk); i_peer_load <= 4'h0;
    waitn(2);
    per_pulse(16'h20);
    chk("trig load", 32'h1, ld);
    chk("trig period", 32'h30, o_period_limit);
    wr(pwr_pkg::OFF_RLDCFG, 32'hc2);
    wr(pwr_pkg::OFF_PERIOD, 32'h40);
    @(posedge i_mclk); i_timer <= 16'h30; i_peer_load <= 4'h4;
    @(posedge i_mclk);
    i_peer_load <= 4'h0;
    @(posedge i_mclk);
    i_timer <= 16'h0;
    chk("coincident now", 32'h0, o_load_event);
    per_pulse(16'h5);
    chk("coincident", 32'h0, ld);
    per_pulse(16'h30);
    chk("next period", 32'h40, o_period_limit);
  endtask

  task automatic t_flags;
    wr(pwr_pkg::OFF_FLAGS, 32'h0);
    @(posedge i_mclk); i_start_match <= 1'b1;
    rd("start flag", pwr_pkg::OFF_FLAGS, 32'h4);
    chk("irq masked", 32'h0, o_irq);
    wr(pwr_pkg::OFF_IRQ_EN, 32'h4);
    waitn(2);
    chk("irq on", 32'h1, o_irq);
    wr(pwr_pkg::OFF_FLAGS, 32'h0);
    rd("level no set", pwr_pkg::OFF_FLAGS, 32'h0);
    @(posedge i_mclk); i_duty_match <= 1'b1;
    rd("duty flag", pwr_pkg::OFF_FLAGS, 32'h2);
    per_pulse(16'h40);
    rd("period flag", pwr_pkg::OFF_FLAGS, 32'hb);
    wr(pwr_pkg::OFF_CTRL, 32'h0);
    rd("off flags", pwr_pkg::OFF_FLAGS, 32'h0);
    chk("off irq", 32'h0, o_irq);
    @(posedge i_mclk); i_start_match <= 1'b0; i_duty_match <= 1'b0;
  endtask

  task automatic t_sync;
    wr(pwr_pkg::OFF_SYNC, 32'h5);
    wr(pwr_pkg::OFF_SYNCFG, 32'h1);
    wr(pwr_pkg::OFF_CTRL, 32'h8c);
    @(posedge i_mclk); i_timer <= 16'h5; i_count_down <= 1'b0;
    waitn(3);
    chk("dn sel up", 32'h0, o_sync_match);
    @(posedge i_mclk); i_count_down <= 1'b1;
    waitn(3);
    chk("dn sel dn", 32'h1, o_sync_match);
    wr(pwr_pkg::OFF_SYNCFG, 32'h0);
    @(posedge i_mclk); i_count_down <= 1'b0;
    waitn(3);
    chk("dir held", 32'h0, o_sync_match);
    wr(pwr_pkg::OFF_CTRL, 32'h80);
    waitn(3);
    chk("std ignore", 32'h1, o_sync_match);
    wr(pwr_pkg::OFF_CTRL, 32'h8c);
    wr(pwr_pkg::OFF_RLDCFG, 32'h80);
    per_pulse(16'h40);
    @(posedge i_mclk); i_timer <= 16'h5;
    waitn(3);
    chk("up sel up", 32'h1, o_sync_match);
  endtask

  task automatic tick_cnt(input string nm, input logic [31:0] exp);
    logic [31:0] c;
    c = 0;
    waitn(4);
    repeat (32) begin
      @(posedge i_mclk);
      if (o_pwm_tick === 1'b1) c++;
    end
    chk(nm, exp, c);
  endtask

  task automatic t_clk;
    wr(pwr_pkg::OFF_CTRL, 32'h80);
    wr(pwr_pkg::OFF_CLKCFG, 32'h10);
    tick_cnt("div2", 32'd16);
    wr(pwr_pkg::OFF_CLKCFG, 32'h00);
    tick_cnt("div1", 32'd32);
    @(posedge i_mclk); i_sleep <= 1'b1;
    tick_cnt("sys sleep", 32'd0);
    wr(pwr_pkg::OFF_CLKCFG, 32'h01);
    tick_cnt("fast sleep", 32'd4);
    wr(pwr_pkg::OFF_CLKCFG, 32'h03);
    tick_cnt("reserved src", 32'd0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    waitn(4);
    i_reset_n <= 1'b1;
    t_regs();
    t_reload();
    t_trig();
    t_flags();
    t_sync();
    t_clk();
    test_done();
  end
endmodule // tb_top
